/* File: bench/uftx_line_partner.sv */
// Remote serial partner: samples the line mid-bit and reports each frame.
// Assumes async mode with a fixed bit period counted in system clocks.
module uftx_line_partner #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic       clock,
  input  wire logic       txd,
  input  wire logic [3:0] nbits,
  input  wire logic       par_en,
  input  wire logic       two_stop,
  output logic            rxd,
  output logic [8:0]      got_data,
  output logic            got_par,
  output logic [1:0]      got_stop,
  output logic            got_start,
  output int              frames
);
  timeunit 1ns;
  timeprecision 1ns;
  // Loopback: the pulled-up line returns to the receiver
  assign rxd = txd;
  initial frames = 0;
  always begin
    @(posedge clock);
    if (txd === 1'b0) begin
      repeat (BIT_CLKS / 2) @(posedge clock);
      got_start = txd;
      got_data = '0;
      got_par = 1'b0;
      for (int i = 0; i < nbits; i++) begin
        repeat (BIT_CLKS) @(posedge clock);
        got_data[i] = txd;
      end
      if (par_en) begin
        repeat (BIT_CLKS) @(posedge clock);
        got_par = txd;
      end
      repeat (BIT_CLKS) @(posedge clock);
      got_stop = {1'b1, txd};
      // Second stop sampled only for checking
      if (two_stop) begin
        repeat (BIT_CLKS) @(posedge clock);
        got_stop[1] = txd;
      end
      frames++;
    end
  end
endmodule : uftx_line_partner

/* File: bench/uftx_transmitter_tb.sv */
// Self-checking bench for the serial frame transmitter.
// Assumes baud_div 0, so one bit lasts 16 system clocks.
module uftx_transmitter_tb
  import uftx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clock, rst_n, psel, penable, pwrite, pready, pslverr, perr;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              txd_out, txd_oe, rxd, par_en, two_stop, got_par, got_start, sco, line;
  logic [3:0]        nbits;
  logic [8:0]        got_data;
  logic [1:0]        got_stop;
  int                frames, n_fail, checked;
  localparam logic [2:0] T_CODE [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h7};
  localparam logic [1:0] T_PM [6]   = '{2'h0, 2'h2, 2'h3, 2'h2, 2'h3, 2'h3};
  localparam logic [8:0] T_DAT [6]  = '{9'h1F5, 9'h02A, 9'h07F, 9'h0A5, 9'h03C, 9'h1A5};

  uftx_transmitter uftx_transmitter_inst (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd_in(rxd), .txd_out(txd_out), .txd_oe(txd_oe), .sync_clk_in(1'b0),
    .sync_clk_out(), .sync_clk_oe(sco));
  // Pull-up holds the line high once the pin is released
  assign line = txd_oe ? txd_out : 1'b1;
  uftx_line_partner uftx_line_partner_inst (
    .clock(clock), .txd(line), .nbits(nbits), .par_en(par_en), .two_stop(two_stop),
    .rxd(rxd), .got_data(got_data), .got_par(got_par), .got_stop(got_stop),
    .got_start(got_start), .frames(frames));

  always #10 clock = ~clock;

  task automatic end_sim;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
      if (i == 19) begin n_fail++; $display("Timeout on bus"); end_sim(); end
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wait_bound(input bit frm, input int n);
    int tgt;
    tgt = frames + n;
    for (int i = 0; i < 400 * n; i++) begin
      if (frm ? frames >= tgt : txd_out === 1'b0) return;
      @(posedge clock);
    end
    n_fail++;
    $display("Timeout on line");
    end_sim();
  endtask : wait_bound

  task automatic cfg(input logic [2:0] code, input logic [1:0] pm, input logic stop, input logic ninth);
    nbits = (code == 3'h7) ? 4'h9 : 4'(code) + 4'h5;
    par_en = pm[1];
    two_stop = stop;
    // No interrupts in this block; format set before any data
    apb(1'b1, OFS_CSB, {27'h0, 1'b1, 1'b1, code[2], 1'b0, ninth});
    apb(1'b1, OFS_CSC, {24'h0, 1'b1, 1'b0, pm, stop, code[1:0], 1'b0});
  endtask : cfg

  task automatic test_reset;
    chk(32'(txd_out), 32'h1);
    chk(32'(txd_oe), 32'h0);
    chk(32'(sco), 32'h0);
    apb(1'b0, OFS_CSA, '0);
    chk(rd, 32'h0000_0020);
    apb(1'b0, OFS_CSC, '0);
    chk(rd, 32'h0000_0086);
    apb(1'b1, OFS_CSC, '0);
    apb(1'b1, OFS_BDL, '0);
    apb(1'b0, OFS_CSC, '0);
    chk(rd, 32'h0000_0086);
    apb(1'b0, 5'h14, '0);
    chk(32'(perr), 32'h1);
    $display("done: reset");
  endtask : test_reset

  task automatic test_formats;
    logic [8:0] exp;
    for (int k = 0; k < 6; k++) begin
      cfg(T_CODE[k], T_PM[k], 1'(k % 2), T_DAT[k][8]);
      chk(32'(txd_oe), 32'h1);
      apb(1'b1, OFS_DATA, 32'(T_DAT[k][7:0]));
      wait_bound(1'b1, 1);
      exp = T_DAT[k] & 9'((1 << nbits) - 1);
      chk(32'(got_start), 32'h0);
      chk(32'(got_data), 32'(exp));
      if (T_PM[k][1]) chk(32'(got_par), 32'(^exp ^ T_PM[k][0]));
      chk(32'(got_stop), 32'h3);
      repeat (32) @(posedge clock);
      apb(1'b0, OFS_CSA, '0);
      chk(rd, 32'h0000_00E0);
      apb(1'b0, OFS_DATA, '0);
      chk(rd, 32'(exp[7:0]));
    end
    $display("done: formats");
  endtask : test_formats

  task automatic test_back2back;
    cfg(3'h3, 2'h0, 1'b0, 1'b0);
    apb(1'b1, OFS_CSA, 32'h0000_0040);
    apb(1'b1, OFS_DATA, 32'h0000_0081);
    wait_bound(1'b0, 1);
    apb(1'b1, OFS_DATA, 32'h0000_007E);
    apb(1'b0, OFS_CSA, '0);
    chk(32'(rd[6:5]), 32'h0);
    wait_bound(1'b1, 1);
    chk(32'(got_data), 32'h0000_0081);
    wait_bound(1'b1, 1);
    chk(32'(got_data), 32'h0000_007E);
    repeat (16) @(posedge clock);
    apb(1'b0, OFS_CSA, '0);
    chk(32'(rd[6:5]), 32'h3);
    $display("done: back to back");
  endtask : test_back2back

  task automatic test_disable;
    cfg(3'h3, 2'h0, 1'b1, 1'b0);
    apb(1'b1, OFS_DATA, 32'h0000_0033);
    wait_bound(1'b0, 1);
    apb(1'b1, OFS_CSB, '0);
    chk(32'(txd_oe), 32'h1);
    wait_bound(1'b1, 1);
    chk(32'(got_data), 32'h0000_0033);
    chk(32'(got_stop), 32'h3);
    repeat (32) @(posedge clock);
    chk(32'(txd_oe), 32'h0);
    $display("done: disable");
  endtask : test_disable

  initial begin
    clock = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; n_fail = 0; checked = 0;
    nbits = 4'h8; par_en = 1'b0; two_stop = 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    test_reset();
    test_formats();
    test_back2back();
    test_disable();
    end_sim();
  end
endmodule : uftx_transmitter_tb

/* File: core/uftx_pkg.sv */
// Constants, register map and state types for the serial frame transmitter.
// Assumes an APB master on the system clock and a remote serial partner on the line.
package uftx_pkg;

  localparam int APB_AW = 5;

  // Register byte offsets
  localparam logic [APB_AW-1:0] OFS_DATA = 5'h00;
  localparam logic [APB_AW-1:0] OFS_CSA  = 5'h04;
  localparam logic [APB_AW-1:0] OFS_CSB  = 5'h08;
  localparam logic [APB_AW-1:0] OFS_CSC  = 5'h0C;
  localparam logic [APB_AW-1:0] OFS_BDL  = 5'h10;

  // ctrl_status_a bits
  localparam int BIT_RX_READY  = 7;
  localparam int BIT_TX_DONE   = 6;
  localparam int BIT_TX_EMPTY  = 5;
  localparam int BIT_FRAME_ERR = 4;
  localparam int BIT_DOUBLE    = 1;
  // ctrl_status_b bits
  localparam int BIT_SYNC_MSTR = 7;
  localparam int BIT_RX_EN     = 4;
  localparam int BIT_TX_EN     = 3;
  localparam int BIT_SIZE_HI   = 2;
  localparam int BIT_NINTH     = 0;
  // ctrl_status_c bits
  localparam int BIT_REG_SEL   = 7;
  localparam int BIT_SYNC_MODE = 6;
  localparam int BIT_PM_HI     = 5;
  localparam int BIT_PM_LO     = 4;
  localparam int BIT_STOP      = 3;
  localparam int BIT_SIZE_MID  = 2;
  localparam int BIT_SIZE_LO   = 1;
  localparam int BIT_CLK_POL   = 0;

  localparam int BAUD_W   = 12;
  localparam int BAUD_LOW = 8;
  localparam int DATA_W   = 9;

  // Oversampling counts (last value of the count) and mid-bit sample points
  localparam logic [3:0] OSR_NORMAL  = 4'hF;
  localparam logic [3:0] OSR_DOUBLE  = 4'h7;
  localparam logic [3:0] HALF_NORMAL = 4'h7;
  localparam logic [3:0] HALF_DOUBLE = 4'h3;

  localparam logic [2:0] SIZE_NINE    = 3'h7;
  localparam logic [2:0] SIZE_DEFAULT = 3'h3;
  localparam logic [3:0] BITS_MIN     = 4'h5;
  localparam logic [3:0] BITS_EIGHT   = 4'h8;
  localparam logic [3:0] BITS_NINE    = 4'h9;

  typedef enum logic [2:0] {
    TX_IDLE,
    TX_START,
    TX_DATA,
    TX_PARITY,
    TX_STOP1,
    TX_STOP2
  } uftx_tx_state_t;

  typedef struct packed {
    logic              double_speed;
    logic              rx_enable;
    logic              tx_enable;
    logic              tx_ninth_bit;
    logic              sync_master;
    logic              sync_mode;
    logic [1:0]        parity_mode_sel;
    logic              stop_bits_sel;
    logic [2:0]        char_size_sel;
    logic              clk_pol;
    logic [BAUD_W-1:0] baud_div;
  } uftx_cfg_t;

  localparam uftx_cfg_t CFG_RESET = '{char_size_sel: SIZE_DEFAULT, default: '0};

endpackage : uftx_pkg

/* File: core/uftx_transmitter.sv */
// Serial frame transmitter with its APB register file and a small frame receiver.
// Assumes APB on clock; rxd_in and sync_clk_in are asynchronous pins.
//
// Chosen here: register access over APB and the placing of the registers.
module uftx_transmitter
  import uftx_pkg::*;
(
  // System
  input  wire logic              clock,
  input  wire logic              rst_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Serial line
  input  wire logic              rxd_in,
  output logic                   txd_out,
  output logic                   txd_oe,
  // Sync clock pin
  input  wire logic              sync_clk_in,
  output logic                   sync_clk_out,
  output logic                   sync_clk_oe
);

  typedef struct packed {
    uftx_cfg_t         cfg;
    logic [BAUD_W-1:0] baud_cnt;
    logic [3:0]        tx_pre;
    logic              xck_out;
    logic [2:0]        xck_sync;
    logic [1:0]        rx_sync;
    logic [DATA_W-1:0] txbuf;
    logic              buf_full;
    logic              tx_done;
    logic              tx_on;
    uftx_tx_state_t    tx_st;
    logic [DATA_W-1:0] sh;
    logic [3:0]        bit_cnt;
    logic              par;
    logic              txd;
    logic              rx_busy;
    logic [3:0]        rx_phase;
    logic [3:0]        rx_cnt;
    logic [DATA_W-1:0] rx_sh;
    logic [DATA_W-1:0] rx_data;
    logic              rx_ready;
    logic              frame_err;
    logic [31:0]       rdata;
  } uftx_state_t;

  uftx_state_t s;
  uftx_state_t next_s;

  function automatic logic [3:0] data_bits(input logic [2:0] code);
    logic [3:0] n;
    n = BITS_EIGHT;
    if (code == SIZE_NINE) begin
      n = BITS_NINE;
    end else if (code <= SIZE_DEFAULT) begin
      n = BITS_MIN + {1'b0, code};
    end
    return n;
  endfunction : data_bits

  function automatic logic [DATA_W-1:0] data_mask(input logic [3:0] n);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < DATA_W; i++) begin
      m[i] = (4'(i) < n);
    end
    return m;
  endfunction : data_mask

  function automatic logic addr_ok(input logic [APB_AW-1:0] a);
    return (a == OFS_DATA) || (a == OFS_CSA) || (a == OFS_CSB) || (a == OFS_CSC) || (a == OFS_BDL);
  endfunction : addr_ok

  logic       setup;
  logic       access;
  logic       wr;
  logic       baud_tick;
  logic       bit_tick;
  logic       frame_end;
  logic       rx_stop;
  logic [3:0] nbits;
  logic       par_en;
  logic [3:0] osr_max;
  logic [3:0] rx_half;
  logic [3:0] rx_stop_idx;
  logic       xck_rise;
  logic       xck_fall;

  assign nbits    = data_bits(s.cfg.char_size_sel);
  // Upper parity mode bit enables parity
  assign par_en   = s.cfg.parity_mode_sel[1];
  assign osr_max  = s.cfg.double_speed ? OSR_DOUBLE : OSR_NORMAL;
  assign rx_half  = s.cfg.double_speed ? HALF_DOUBLE : HALF_NORMAL;
  assign rx_stop_idx = nbits + {3'b000, par_en} + 4'h1;

  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign wr       = access && pwrite && addr_ok(paddr);
  assign pready   = access;
  assign pslverr  = access && !addr_ok(paddr);
  assign prdata   = s.rdata;

  // Second and third stage only; first stage feeds nothing else
  assign xck_rise = s.xck_sync[1] && !s.xck_sync[2];
  assign xck_fall = !s.xck_sync[1] && s.xck_sync[2];
  assign baud_tick = (s.baud_cnt == '0);

  // Bit pace: divider in async mode, sync clock change edge otherwise
  always_comb begin
    if (!s.cfg.sync_mode) begin
      bit_tick = baud_tick && (s.tx_pre == osr_max);
    end else if (s.cfg.sync_master) begin
      bit_tick = baud_tick && (s.xck_out == s.cfg.clk_pol);
    end else begin
      bit_tick = s.cfg.clk_pol ? xck_fall : xck_rise;
    end
  end

  assign txd_out = s.txd;
  // Pin override follows the held enable
  assign txd_oe = s.tx_on;
  // Sync clock pin taken over while transmitting synchronously as sync master
  assign sync_clk_oe  = s.tx_on && s.cfg.sync_mode && s.cfg.sync_master;
  assign sync_clk_out = s.xck_out;

  always_comb begin
    next_s = s;
    frame_end = 1'b0;
    rx_stop = 1'b0;

    // Synchronisers
    next_s.xck_sync = {s.xck_sync[1:0], sync_clk_in};
    next_s.rx_sync  = {s.rx_sync[0], rxd_in};

    // Baud divider, restarted when the low byte is written
    if (baud_tick || (wr && paddr == OFS_BDL)) begin
      next_s.baud_cnt = s.cfg.baud_div;
    end else begin
      next_s.baud_cnt = s.baud_cnt - 1'b1;
    end
    if (baud_tick) begin
      next_s.tx_pre  = (s.tx_pre == osr_max) ? 4'h0 : s.tx_pre + 4'h1;
      next_s.xck_out = s.cfg.sync_mode && s.cfg.sync_master ? !s.xck_out : s.cfg.clk_pol;
    end

    // Read data captured in setup; answer one cycle later
    if (setup) begin
      next_s.rdata = '0;
      unique case (paddr)
        OFS_DATA: next_s.rdata[DATA_W-2:0] = s.rx_data[DATA_W-2:0];
        OFS_CSA: begin
          next_s.rdata[BIT_RX_READY]  = s.rx_ready;
          next_s.rdata[BIT_TX_DONE]   = s.tx_done;
          next_s.rdata[BIT_TX_EMPTY]  = !s.buf_full;
          next_s.rdata[BIT_FRAME_ERR] = s.frame_err;
          next_s.rdata[BIT_DOUBLE]    = s.cfg.double_speed;
        end
        OFS_CSB: begin
          next_s.rdata[BIT_SYNC_MSTR] = s.cfg.sync_master;
          next_s.rdata[BIT_RX_EN]     = s.cfg.rx_enable;
          next_s.rdata[BIT_TX_EN]     = s.cfg.tx_enable;
          next_s.rdata[BIT_SIZE_HI]   = s.cfg.char_size_sel[2];
          next_s.rdata[BIT_NINTH]     = s.cfg.tx_ninth_bit;
        end
        OFS_CSC: begin
          next_s.rdata[BIT_REG_SEL]               = 1'b1;
          next_s.rdata[BIT_SYNC_MODE]             = s.cfg.sync_mode;
          next_s.rdata[BIT_PM_HI:BIT_PM_LO]       = s.cfg.parity_mode_sel;
          next_s.rdata[BIT_STOP]                  = s.cfg.stop_bits_sel;
          next_s.rdata[BIT_SIZE_MID:BIT_SIZE_LO]  = s.cfg.char_size_sel[1:0];
          next_s.rdata[BIT_CLK_POL]               = s.cfg.clk_pol;
        end
        OFS_BDL: next_s.rdata[BAUD_LOW-1:0] = s.cfg.baud_div[BAUD_LOW-1:0];
        default: next_s.rdata = '0;
      endcase
    end

    // Register writes set the frame format
    if (wr) begin
      unique case (paddr)
        OFS_CSA: begin
          next_s.cfg.double_speed = pwdata[BIT_DOUBLE];
          if (pwdata[BIT_TX_DONE]) begin
            next_s.tx_done = 1'b0;
          end
        end
        OFS_CSB: begin
          next_s.cfg.sync_master      = pwdata[BIT_SYNC_MSTR];
          next_s.cfg.rx_enable        = pwdata[BIT_RX_EN];
          next_s.cfg.tx_enable        = pwdata[BIT_TX_EN];
          next_s.cfg.char_size_sel[2] = pwdata[BIT_SIZE_HI];
          next_s.cfg.tx_ninth_bit     = pwdata[BIT_NINTH];
        end
        OFS_CSC: begin
          // Top bit picks control C over the baud high byte
          if (pwdata[BIT_REG_SEL]) begin
            next_s.cfg.sync_mode          = pwdata[BIT_SYNC_MODE];
            next_s.cfg.parity_mode_sel    = pwdata[BIT_PM_HI:BIT_PM_LO];
            next_s.cfg.stop_bits_sel      = pwdata[BIT_STOP];
            next_s.cfg.char_size_sel[1:0] = pwdata[BIT_SIZE_MID:BIT_SIZE_LO];
            next_s.cfg.clk_pol            = pwdata[BIT_CLK_POL];
          end else begin
            next_s.cfg.baud_div[BAUD_W-1:BAUD_LOW] = pwdata[BAUD_W-BAUD_LOW-1:0];
          end
        end
        OFS_BDL: next_s.cfg.baud_div[BAUD_LOW-1:0] = pwdata[BAUD_LOW-1:0];
        default: ;
      endcase
    end
    // Reading data port frees the receive slot; a new frame below still wins
    if (access && !pwrite && paddr == OFS_DATA) begin
      next_s.rx_ready = 1'b0;
    end

    // Enable held until shifter and buffer have drained
    if (s.cfg.tx_enable) begin
      next_s.tx_on = 1'b1;
    end else if (s.tx_st == TX_IDLE && !s.buf_full) begin
      next_s.tx_on = 1'b0;
    end

    // Transmit sequencer covers all thirty formats
    unique case (s.tx_st)
      TX_IDLE: begin
        next_s.txd = 1'b1;
      end
      TX_START: begin
        // Least significant data bit follows start
        if (bit_tick) begin
          next_s.txd     = s.sh[0];
          next_s.sh      = s.sh >> 1;
          next_s.bit_cnt = 4'h1;
          next_s.tx_st   = TX_DATA;
        end
      end
      TX_DATA: begin
        if (bit_tick) begin
          if (s.bit_cnt == nbits) begin
            // Parity right after last data bit
            next_s.txd   = par_en ? s.par : 1'b1;
            next_s.tx_st = par_en ? TX_PARITY : TX_STOP1;
          end else begin
            next_s.txd     = s.sh[0];
            next_s.sh      = s.sh >> 1;
            next_s.bit_cnt = s.bit_cnt + 4'h1;
          end
        end
      end
      TX_PARITY: begin
        if (bit_tick) begin
          next_s.txd   = 1'b1;
          next_s.tx_st = TX_STOP1;
        end
      end
      TX_STOP1: begin
        if (bit_tick) begin
          if (s.cfg.stop_bits_sel) begin
            next_s.tx_st = TX_STOP2;
          end else begin
            frame_end = 1'b1;
          end
        end
      end
      TX_STOP2: begin
        if (bit_tick) begin
          frame_end = 1'b1;
        end
      end
    endcase

    // Load when idle or straight after the last stop bit
    if ((s.tx_st == TX_IDLE && bit_tick) || frame_end) begin
      if (s.buf_full && s.tx_on) begin
        next_s.sh       = s.txbuf & data_mask(nbits);
        // Even is xor of data, odd inverts it
        next_s.par      = (^(s.txbuf & data_mask(nbits))) ^ s.cfg.parity_mode_sel[0];
        next_s.txd      = 1'b0;
        next_s.tx_st    = TX_START;
        // Buffer empties on transfer to shifter
        next_s.buf_full = 1'b0;
      end else if (frame_end) begin
        // Back to idle high without new data
        next_s.txd     = 1'b1;
        next_s.tx_st   = TX_IDLE;
        next_s.tx_done = 1'b1;
      end
    end

    // Data port write fills the buffer; its frame starts at the next load
    if (wr && paddr == OFS_DATA) begin
      // Ninth bit taken from control B at write time
      next_s.txbuf    = {s.cfg.tx_ninth_bit, pwdata[BAUD_LOW-1:0]};
      next_s.buf_full = 1'b1;
    end

    // Receiver, asynchronous frames only, sampled mid-bit
    if (!s.cfg.rx_enable) begin
      next_s.rx_busy = 1'b0;
    end else if (baud_tick) begin
      if (!s.rx_busy) begin
        if (!s.rx_sync[1]) begin
          next_s.rx_busy  = 1'b1;
          next_s.rx_phase = 4'h0;
          next_s.rx_cnt   = 4'h0;
        end
      end else begin
        next_s.rx_phase = (s.rx_phase == osr_max) ? 4'h0 : s.rx_phase + 4'h1;
        if (s.rx_phase == rx_half) begin
          next_s.rx_cnt = s.rx_cnt + 4'h1;
          if (s.rx_cnt == 4'h0 && s.rx_sync[1]) begin
            next_s.rx_busy = 1'b0;
          end else if (s.rx_cnt == rx_stop_idx) begin
            // Only first stop bit checked; second ignored
            rx_stop          = 1'b1;
            next_s.frame_err = !s.rx_sync[1];
            next_s.rx_data   = s.rx_sh & data_mask(nbits);
            next_s.rx_ready  = 1'b1;
            next_s.rx_busy   = 1'b0;
          end else if (s.rx_cnt != 4'h0 && s.rx_cnt <= nbits) begin
            next_s.rx_sh[s.rx_cnt - 4'h1] = s.rx_sync[1];
          end
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s          <= '0;
      s.cfg      <= CFG_RESET;
      s.txd      <= 1'b1;
      s.xck_sync <= '0;
      s.rx_sync  <= 2'b11;
      s.tx_st    <= TX_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_data_write;
    psel && penable && pwrite && (paddr == OFS_DATA);
  endsequence

  sequence s_last_stop_free;
    frame_end && !(s.buf_full && s.tx_on) && !(wr && paddr == OFS_DATA);
  endsequence

  sequence s_start_shift;
    (s.tx_st == TX_START) && bit_tick;
  endsequence

  a_buf_flag_clear: assert property (s_data_write |=> s.buf_full)
    else $error("buffer empty flag not cleared by data write");
  a_start_low: assert property ((s.tx_st == TX_START) |-> !txd_out && txd_oe)
    else $error("start bit not low");
  a_stop_high: assert property ((s.tx_st == TX_STOP1 || s.tx_st == TX_STOP2) |-> txd_out)
    else $error("stop bit not high");
  a_idle_line: assert property ((s.tx_st == TX_IDLE) |-> txd_out)
    else $error("idle line not high");
  a_lsb_first: assert property (s_start_shift |=> txd_out == $past(s.sh[0]) && s.tx_st == TX_DATA)
    else $error("first data bit not lsb");
  a_parity_value: assert property ((s.tx_st == TX_START) |-> s.par == ((^s.sh) ^ s.cfg.parity_mode_sel[0]))
    else $error("parity value wrong");
  a_parity_slot: assert property ((s.tx_st == TX_PARITY) |-> txd_out == s.par && $past(s.tx_st) != TX_STOP1)
    else $error("parity bit misplaced");
  a_two_stops: assert property ((s.tx_st == TX_STOP1) && bit_tick && s.cfg.stop_bits_sel |=> s.tx_st == TX_STOP2)
    else $error("second stop bit missing");
  a_done_flag: assert property (s_last_stop_free |=> s.tx_done && s.tx_st == TX_IDLE)
    else $error("done flag not set at frame end");
  a_pin_held: assert property (!s.cfg.tx_enable && (s.tx_st != TX_IDLE || s.buf_full) && s.tx_on |=> txd_oe)
    else $error("pin released with data pending");
  a_frame_err: assert property (rx_stop |=> s.frame_err == !$past(s.rx_sync[1]) && s.rx_ready)
    else $error("framing error flag wrong");

endmodule : uftx_transmitter
